// file: bench/parallel_channel_service_request_test.sv
// Purpose: self-checking bench of the service request block
// Assumes: host model drives the register port and acknowledges
// Notes:   summary register read before the first service acknowledge
`timescale 1ns/100ps
`include "pcsr_defines.svh"
module parallel_channel_service_request_test;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic        PIPE_SERVICE_NEED, PIPE_DATA_ERROR, FIFO_THRESHOLD_HIT, FIFO_NEAR_LIMIT;
  logic        PIPE_WORD_VALID, MANUAL_MODE, COMPAT_MODE, ECP_MODE, ECP_REVERSE;
  logic        EPP_ADDR_STROBE, ID_REQUEST, INIT_PULSE;
  logic [7:0]  DATA_ERROR_CAUSE, NEG_STATE, SIGNAL_STATE, EPP_ADDR, mask;
  logic [15:0] PIPE_WORD, DATA_IN, DATA_OUT, DMA_TX_WORD, rd_v;
  logic [4:0]  ADDR;
  logic        CS_N, DS_N, READ_NOT_WRITE, SVC_ACK_IN_N, DMA_ACK_IN_N, CHAIN_GRANT_IN_N;
  logic        DATA_OE, TRANSFER_ACK_OUT_N, SVC_REQUEST_OUT_N, DMA_REQUEST_OUT_N;
  logic        CHAIN_PASS_OUT_N, DMA_TX_LOAD, ok_v, ps_v;
  int          err_count = 0;
  int          n_tests = 0;
  int          n_load = 0;

  always #10 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (DMA_TX_LOAD === 1'b1) n_load++;

  pcsr_host_model host_u (
    .clk(CLOCK), .transfer_ack_out_n(TRANSFER_ACK_OUT_N), .pass_n(CHAIN_PASS_OUT_N), .rdata(DATA_OUT),
    .cs_n(CS_N), .ds_n(DS_N), .rnw(READ_NOT_WRITE), .addr(ADDR), .wdata(DATA_IN),
    .ack_n(SVC_ACK_IN_N), .grant_n(CHAIN_GRANT_IN_N), .dack_n(DMA_ACK_IN_N)
  );

  pcsr_top dut_u (
    .CLOCK, .RST_N, .CS_N, .DS_N, .READ_NOT_WRITE, .ADDR, .DATA_IN, .DATA_OUT, .DATA_OE,
    .TRANSFER_ACK_OUT_N, .SVC_REQUEST_OUT_N, .SVC_ACK_IN_N, .DMA_REQUEST_OUT_N,
    .DMA_ACK_IN_N, .CHAIN_GRANT_IN_N, .CHAIN_PASS_OUT_N, .PIPE_SERVICE_NEED,
    .PIPE_DATA_ERROR, .DATA_ERROR_CAUSE, .FIFO_THRESHOLD_HIT, .FIFO_NEAR_LIMIT,
    .PIPE_WORD_VALID, .PIPE_WORD, .DMA_TX_WORD, .DMA_TX_LOAD, .NEG_STATE, .SIGNAL_STATE,
    .MANUAL_MODE, .COMPAT_MODE, .ECP_MODE, .ECP_REVERSE, .EPP_ADDR_STROBE, .EPP_ADDR,
    .ID_REQUEST, .INIT_PULSE
  );

  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    host_u.acc(1, a, d, rd_v, ok_v, ps_v);
  endtask

  task rd(input logic [4:0] a);
    host_u.acc(0, a, 16'h0000, rd_v, ok_v, ps_v);
  endtask

  task ack(input int k);
    host_u.acc(k, 5'h00, 16'h0000, rd_v, ok_v, ps_v);
  endtask

  task step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    test_done;
  end

  initial begin
    {PIPE_SERVICE_NEED, PIPE_DATA_ERROR, FIFO_THRESHOLD_HIT, FIFO_NEAR_LIMIT} = 4'h0;
    {PIPE_WORD_VALID, MANUAL_MODE, COMPAT_MODE, ECP_REVERSE} = 4'h0;
    {EPP_ADDR_STROBE, ID_REQUEST, INIT_PULSE} = 3'h0;
    ECP_MODE = 1'b1;
    {DATA_ERROR_CAUSE, NEG_STATE, SIGNAL_STATE, EPP_ADDR} = 32'h0;
    PIPE_WORD = 16'h0000;
    step(8);
    RST_N = 1'b1;
    step(2);
    chk({11'h0, SVC_REQUEST_OUT_N, DMA_REQUEST_OUT_N, CHAIN_PASS_OUT_N,
         TRANSFER_ACK_OUT_N, DATA_OE}, 16'h001E);
    rd(5'h1F);
    chk(rd_v, 16'h0000);
    wr(`PCSR_OFS_CHANNEL_SELECT, 16'h0000);
    wr(`PCSR_OFS_LOCAL_VECTOR, 16'h00AF);
    rd(`PCSR_OFS_LOCAL_VECTOR);
    chk(rd_v, 16'h00A8);
    wr(`PCSR_OFS_CHANNEL_SELECT, 16'h0001);
    rd(`PCSR_OFS_LOCAL_VECTOR);
    chk(rd_v, 16'h0000);
    wr(`PCSR_OFS_CHANNEL_SELECT, 16'h0000);
    $display("vector test done");

    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0050);
    FIFO_THRESHOLD_HIT = 1'b1;
    step(4);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0001);
    chk({15'h0, DMA_REQUEST_OUT_N}, 16'h0000);
    rd(`PCSR_OFS_SUMMARY_SVC);
    chk(rd_v, 16'h0080);
    FIFO_THRESHOLD_HIT = 1'b0;
    FIFO_NEAR_LIMIT = 1'b1;
    step(4);
    chk({15'h0, DMA_REQUEST_OUT_N}, 16'h0001);
    FIFO_NEAR_LIMIT = 1'b0;
    FIFO_THRESHOLD_HIT = 1'b1;
    step(4);
    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0010);
    chk({15'h0, DMA_REQUEST_OUT_N}, 16'h0001);
    FIFO_THRESHOLD_HIT = 1'b0;
    $display("dma request test done");

    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0000);
    PIPE_SERVICE_NEED = 1'b1;
    step(6);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0001);
    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0010);
    step(6);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0000);
    rd(`PCSR_OFS_REQ_FLAGS);
    chk(rd_v, 16'h00A0);
    rd(`PCSR_OFS_SUMMARY_SVC);
    chk(rd_v, 16'h0008);
    ack(3);
    chk({15'h0, ok_v}, 16'h0000);
    ack(2);
    chk(rd_v, 16'h00AD);
    chk({15'h0, ps_v}, 16'h0000);
    step(4);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0001);
    rd(`PCSR_OFS_LOCAL_VECTOR);
    chk(rd_v, 16'h00AD);
    PIPE_SERVICE_NEED = 1'b0;
    wr(`PCSR_OFS_END_OF_SERVICE, 16'h005A);
    rd(`PCSR_OFS_LOCAL_VECTOR);
    chk(rd_v, 16'h00A8);
    rd(`PCSR_OFS_PRESENTED_VEC);
    chk(rd_v, 16'h0000);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0001);
    $display("pipeline request test done");

    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0002);
    DATA_ERROR_CAUSE = 8'h5A;
    PIPE_DATA_ERROR = 1'b1;
    step(6);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0001);
    rd(`PCSR_OFS_DATA_ERR_CAUSE);
    chk(rd_v, 16'h005A);
    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0012);
    step(6);
    chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0000);
    ack(2);
    chk(rd_v, 16'h00AD);
    PIPE_DATA_ERROR = 1'b0;
    wr(`PCSR_OFS_END_OF_SERVICE, 16'h0000);
    $display("error request test done");

    wr(`PCSR_OFS_CHAN_IRQ_EN, 16'h003F);
    SIGNAL_STATE = 8'h01;
    INIT_PULSE = 1'b1;
    step(2);
    INIT_PULSE = 1'b0;
    step(6);
    rd(`PCSR_OFS_CHAN_IRQ_STAT);
    chk(rd_v, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      mask = (i == 6) ? 8'h08 : 8'(1 << i);
      case (i)
        0: NEG_STATE = 8'h01;
        1: begin
          MANUAL_MODE = 1'b1;
          SIGNAL_STATE = 8'h02;
        end
        2: begin
          EPP_ADDR = 8'h3C;
          EPP_ADDR_STROBE = 1'b1;
        end
        3: ECP_REVERSE = 1'b1;
        4: ID_REQUEST = 1'b1;
        5: begin
          COMPAT_MODE = 1'b1;
          INIT_PULSE = 1'b1;
        end
        default: ECP_REVERSE = 1'b0;
      endcase
      step(2);
      {EPP_ADDR_STROBE, ID_REQUEST, INIT_PULSE} = 3'h0;
      step(6);
      chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0000);
      rd(`PCSR_OFS_CHAN_IRQ_STAT);
      chk(rd_v, {8'h00, mask});
      ack(2);
      chk(rd_v, 16'h00AC);
      wr(`PCSR_OFS_CHAN_IRQ_STAT, {8'h00, mask});
      wr(`PCSR_OFS_END_OF_SERVICE, 16'h0000);
      chk({15'h0, SVC_REQUEST_OUT_N}, 16'h0001);
    end
    rd(`PCSR_OFS_NEG_STATUS);
    chk(rd_v, 16'h0001);
    rd(`PCSR_OFS_EPP_ADDRESS);
    chk(rd_v, 16'h003C);
    $display("port request test done");

    PIPE_SERVICE_NEED = 1'b1;
    ID_REQUEST = 1'b1;
    step(2);
    ID_REQUEST = 1'b0;
    step(6);
    ack(2);
    chk(rd_v, 16'h00AE);
    PIPE_SERVICE_NEED = 1'b0;
    wr(`PCSR_OFS_CHAN_IRQ_STAT, 16'h003F);
    wr(`PCSR_OFS_END_OF_SERVICE, 16'h0000);
    ack(2);
    chk({15'h0, ok_v}, 16'h0000);
    chk({15'h0, ps_v}, 16'h0001);
    $display("chain test done");

    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0010);
    wr(`PCSR_OFS_DMA_BUFFER, 16'hBEEF);
    chk(DMA_TX_WORD, 16'hBEEF);
    rd(`PCSR_OFS_DMA_BUFFER);
    chk(rd_v, 16'h0000);
    chk(16'(n_load), 16'h0001);
    host_u.acc(4, 5'h00, 16'h6789, rd_v, ok_v, ps_v);
    chk(DMA_TX_WORD, 16'h6789);
    chk(16'(n_load), 16'h0002);
    wr(`PCSR_OFS_PIPE_CONFIG, 16'h0030);
    PIPE_WORD = 16'h1234;
    PIPE_WORD_VALID = 1'b1;
    step(2);
    PIPE_WORD_VALID = 1'b0;
    // one word held in the buffer: (count + 4) / 2 word reads each return it without draining it
    repeat ((2 + 4) / 2) begin
      rd(`PCSR_OFS_DMA_BUFFER);
      chk(rd_v, 16'h1234);
    end
    host_u.acc(4, 5'h00, 16'h0000, rd_v, ok_v, ps_v);
    chk(rd_v, 16'h1234);
    wr(`PCSR_OFS_DMA_BUFFER, 16'h5555);
    chk(DMA_TX_WORD, 16'h1234);
    chk(16'(n_load), 16'h0002);
    $display("buffer test done");
    test_done;
  end
endmodule // parallel_channel_service_request_test

// file: bench/pcsr_host_model.sv
// Purpose: host CPU side of the register port and of the service acknowledge
// Assumes: requests launched 1 ns after a rising clock edge
// Notes:   an acknowledge nobody answers is cut off after a bounded wait
`timescale 1ns/100ps
module pcsr_host_model (
  input  wire logic        clk,
  input  wire logic        transfer_ack_out_n,
  input  wire logic        pass_n,
  input  wire logic [15:0] rdata,
  output      logic        cs_n,
  output      logic        ds_n,
  output      logic        rnw,
  output      logic [4:0]  addr,
  output      logic [15:0] wdata,
  output      logic        ack_n,
  output      logic        grant_n,
  output      logic        dack_n
);
  // ****************************************
  // bus cycles: kind 0 read, 1 write, 2 acknowledge, 3 acknowledge without grant, 4 dma
  // ****************************************
  initial begin
    {cs_n, ds_n, rnw, ack_n, grant_n} = 5'h1F;
    dack_n = 1'b1;
    addr = 5'h00;
    wdata = 16'h0000;
  end

  // the acknowledge never goes out on a dma request, only on service requests
  task automatic acc(input int k, input logic [4:0] a, input logic [15:0] wd,
                     output logic [15:0] rd, output logic ok, output logic passed);
    int n;
    n = 0;
    ok = 1'b0;
    passed = 1'b0;
    addr = a;
    wdata = wd;
    rnw = (k != 1);
    cs_n = (k >= 2);
    ack_n = (k < 2 || k == 4);
    grant_n = (k != 2);
    dack_n = (k != 4);
    ds_n = (k == 4);
    // bounded wait stands in for the host timeout on an unanswered cycle
    while (n < 40 && !ok) begin
      @(posedge clk);
      n++;
      ok = (transfer_ack_out_n === 1'b0);
      if (pass_n === 1'b0) passed = 1'b1;
    end
    rd = rdata;
    #1;
    {cs_n, ds_n, ack_n, grant_n, dack_n} = 5'h1F;
    wdata = ~wdata;
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule // pcsr_host_model

// file: rtl/pcsr_cycle.sv
// Purpose: CPU bus cycle sequencer on the divided internal clock
// Assumes: strobes synchronous to the system clock
// Notes:   DMA cycles never return TRANSFER_ACK_OUT
`timescale 1ns/100ps
module pcsr_cycle (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              cs_n,
  input  wire logic              ds_n,
  input  wire logic              rw,
  input  wire logic              ack_n,
  input  wire logic              dack_n,
  input  wire logic              grant_ok,
  output      pcsr_pkg::pcsr_cyc_t kind,
  output      logic              go,
  output      logic              transfer_ack_out_n
);
  import pcsr_pkg::*;

  pcsr_cyc_state_t state;
  pcsr_cyc_t       next_kind;

  wire start_reg = !ds_n && !cs_n;
  // without a grant and a pending request the acknowledge is left unanswered
  wire start_ack = !ds_n && cs_n && !ack_n && grant_ok;
  wire start_dma = !dack_n && cs_n && ack_n;
  wire released  = ds_n && dack_n;

  assign next_kind = '{rd: start_reg && rw, wr: start_reg && !rw,
                       svc_ack: start_ack, dma: start_dma};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state   <= CYC_IDLE;
      kind    <= '0;
      go      <= 1'b0;
      transfer_ack_out_n <= 1'b1;
    end else begin
      go <= 1'b0;
      // read data settles one edge after go, so the acknowledge waits for it
      if (go) transfer_ack_out_n <= kind.dma;
      if (ce) begin
        unique case (state)
          CYC_IDLE: begin
            if (start_reg || start_ack || start_dma) begin
              kind  <= next_kind;
              state <= CYC_ACCESS;
            end
          end
          CYC_ACCESS: begin
            go      <= 1'b1;
            state   <= CYC_HOLD;
          end
          CYC_HOLD: begin
            if (released) begin
              transfer_ack_out_n <= 1'b1;
              state   <= CYC_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_no_grant_idle: assert property (
    (ce && state == CYC_IDLE && !ds_n && cs_n && !ack_n && dack_n && !grant_ok)
    |=> (state == CYC_IDLE && transfer_ack_out_n))
    else $error("acknowledge taken without grant");
  a_transfer_ack_out_release: assert property (
    (ce && state == CYC_HOLD && released) |=> transfer_ack_out_n ##1 (state == CYC_IDLE))
    else $error("transfer_ack_out not released after strobes");
  c_ack_cycle: cover property (go && kind.svc_ack);
endmodule // pcsr_cycle

// file: rtl/pcsr_defines.svh
// Purpose: constants of the parallel channel service request block
// Assumes: 8-bit registers, 16-bit DMA word buffer
// Notes:   register offsets are byte addresses on the CPU port
`ifndef PCSR_DEFINES_SVH
`define PCSR_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define PCSR_OFS_CHANNEL_SELECT 5'h00
`define PCSR_OFS_PIPE_CONFIG    5'h01
`define PCSR_OFS_PIPE_STATUS    5'h02
`define PCSR_OFS_DATA_ERR_CAUSE 5'h03
`define PCSR_OFS_CHAN_IRQ_EN    5'h04
`define PCSR_OFS_CHAN_IRQ_STAT  5'h05
`define PCSR_OFS_NEG_STATUS     5'h06
`define PCSR_OFS_SIGNAL_STATUS  5'h07
`define PCSR_OFS_EPP_ADDRESS    5'h08
`define PCSR_OFS_LOCAL_VECTOR   5'h09
`define PCSR_OFS_REQ_FLAGS      5'h0A
`define PCSR_OFS_SUMMARY_SVC    5'h0B
`define PCSR_OFS_END_OF_SERVICE 5'h0C
`define PCSR_OFS_PRESENTED_VEC  5'h0D
`define PCSR_OFS_DMA_BUFFER     5'h0E

// ****************************************
// field positions
// ****************************************
`define PCSR_CFG_DMA_EN   6
`define PCSR_CFG_DMA_DIR  5
`define PCSR_CFG_IRQ_EN   4
`define PCSR_CFG_ERR_EN   1
`define PCSR_STAT_DATA_ERROR_FLAG 0
`define PCSR_FLAG_SUMMARY 7
`define PCSR_FLAG_PORT    6
`define PCSR_FLAG_PIPE    5
`define PCSR_SVC_DMA      7
`define PCSR_SVC_MIRROR   3

// ****************************************
// codes and reset values
// ****************************************
`define PCSR_SRC_NONE 3'h0
`define PCSR_SRC_PORT 3'h4
`define PCSR_SRC_PIPE 3'h5
`define PCSR_SRC_BOTH 3'h6
`define PCSR_CHAN_ZERO 8'h00
`define PCSR_RST8  8'h00
`define PCSR_RST16 16'h0000

`endif

// file: rtl/pcsr_pkg.sv
// Purpose: types shared by the service request block files
// Assumes: nothing beyond the defines header
// Notes:   none
package pcsr_pkg;
  // kind of CPU bus cycle under way
  typedef struct packed {
    logic rd;
    logic wr;
    logic svc_ack;
    logic dma;
  } pcsr_cyc_t;

  // port state machine interrupt causes, bit 0 at the bottom
  typedef struct packed {
    logic init_pulse_irq;
    logic id_request_irq;
    logic direction_change;
    logic epp_addr_write_irq;
    logic signal_change;
    logic negotiation_change;
  } pcsr_port_ev_t;

  typedef enum logic [1:0] {CYC_IDLE, CYC_ACCESS, CYC_HOLD} pcsr_cyc_state_t;
endpackage

// file: rtl/pcsr_top.sv
// Purpose: service request gathering, vectoring and chaining of a parallel channel
// Assumes: all inputs synchronous to CLOCK; host holds ADDR through a cycle
// Notes:   bus cycle sequencer steps on CLOCK divided by two; all other logic steps on every CLOCK
// How it works
// - threshold never raises a service request
// - DMA request holds until near limit, enable clears
// - direction bit picks buffer write or read
// - only granted pending device answers acknowledge
// - granted idle device passes grant on
// - no pending request means no transfer ack to an acknowledge
// - vector upper five bits keep host value
// - pipeline sets bit five, port bit six
// - either source sets summary, mirrored in summary
// - pipeline and port requests have own enables
// - error interrupt needs both enable bits
// - data error bit raises error interrupt
// - six port causes, each enabled, three mode qualified
// - protocol change raises negotiation interrupt
// - ECP direction change raises interrupt
// - ID request raises interrupt
// - EPP address write interrupts, address kept
// - vector low bits read source in service
// - source codes 100, 101, 110
// - acknowledge drops request until end write or pipeline enable flip
// - end write clears context and vector
`timescale 1ns/100ps
`include "pcsr_defines.svh"
module pcsr_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CS_N,
  input  wire logic        DS_N,
  input  wire logic        READ_NOT_WRITE,
  input  wire logic [4:0]  ADDR,
  input  wire logic [15:0] DATA_IN,
  output      logic [15:0] DATA_OUT,
  output      logic        DATA_OE,
  output      logic        TRANSFER_ACK_OUT_N,
  output      logic        SVC_REQUEST_OUT_N,
  input  wire logic        SVC_ACK_IN_N,
  output      logic        DMA_REQUEST_OUT_N,
  input  wire logic        DMA_ACK_IN_N,
  input  wire logic        CHAIN_GRANT_IN_N,
  output      logic        CHAIN_PASS_OUT_N,
  input  wire logic        PIPE_SERVICE_NEED,
  input  wire logic        PIPE_DATA_ERROR,
  input  wire logic [7:0]  DATA_ERROR_CAUSE,
  input  wire logic        FIFO_THRESHOLD_HIT,
  input  wire logic        FIFO_NEAR_LIMIT,
  input  wire logic        PIPE_WORD_VALID,
  input  wire logic [15:0] PIPE_WORD,
  output      logic [15:0] DMA_TX_WORD,
  output      logic        DMA_TX_LOAD,
  input  wire logic [7:0]  NEG_STATE,
  input  wire logic [7:0]  SIGNAL_STATE,
  input  wire logic        MANUAL_MODE,
  input  wire logic        COMPAT_MODE,
  input  wire logic        ECP_MODE,
  input  wire logic        ECP_REVERSE,
  input  wire logic        EPP_ADDR_STROBE,
  input  wire logic [7:0]  EPP_ADDR,
  input  wire logic        ID_REQUEST,
  input  wire logic        INIT_PULSE
);
  import pcsr_pkg::*;

  function automatic logic [2:0] src_code(input logic port, input logic pipe);
    src_code = (port && pipe) ? `PCSR_SRC_BOTH :
               pipe ? `PCSR_SRC_PIPE : port ? `PCSR_SRC_PORT : `PCSR_SRC_NONE;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic          ce;
  logic [7:0]    cfg;
  logic [7:0]    chan_sel;
  logic [5:0]    irq_en;
  pcsr_port_ev_t causes;
  logic [7:5]    flags;
  logic          in_service;
  logic [4:0]    vec_id;
  logic [7:0]    pres_vec;
  logic [7:0]    epp_addr;
  logic [7:0]    neg_prev;
  logic [7:0]    sig_prev;
  logic          rev_prev;
  logic [7:0]    rd_val;
  pcsr_cyc_t     kind;
  logic          go;
  pcsr_port_ev_t ev;
  pcsr_port_ev_t next_causes;
  logic [7:5]    next_flags;
  logic [7:5]    base_flags;

  // ****************************************
  // bus cycles
  // ****************************************
  wire pending  = flags[`PCSR_FLAG_SUMMARY] && !in_service;
  wire grant_ok = !CHAIN_GRANT_IN_N && pending;

  pcsr_cycle u_cycle (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .ce       (ce),
    .cs_n     (CS_N),
    .ds_n     (DS_N),
    .rw       (READ_NOT_WRITE),
    .ack_n    (SVC_ACK_IN_N),
    .dack_n   (DMA_ACK_IN_N),
    .grant_ok (grant_ok),
    .kind     (kind),
    .go       (go),
    .transfer_ack_out_n  (TRANSFER_ACK_OUT_N)
  );

  wire wr_go    = go && kind.wr;
  wire ack_go   = go && kind.svc_ack;
  wire dma_go   = go && kind.dma;
  wire dma_dir  = cfg[`PCSR_CFG_DMA_DIR];
  wire chan0    = chan_sel == `PCSR_CHAN_ZERO;
  wire wr_sel   = wr_go && ADDR == `PCSR_OFS_CHANNEL_SELECT;
  wire wr_cfg   = wr_go && ADDR == `PCSR_OFS_PIPE_CONFIG;
  wire wr_ien   = wr_go && ADDR == `PCSR_OFS_CHAN_IRQ_EN;
  wire wr_stat  = wr_go && ADDR == `PCSR_OFS_CHAN_IRQ_STAT;
  wire wr_vec   = wr_go && ADDR == `PCSR_OFS_LOCAL_VECTOR && chan0;
  wire wr_flags = wr_go && ADDR == `PCSR_OFS_REQ_FLAGS;
  wire eos_wr   = wr_go && ADDR == `PCSR_OFS_END_OF_SERVICE;
  // host writes the buffer only while transmitting, DMA cycle fills it too
  wire wr_buf   = !dma_dir && ((wr_go && ADDR == `PCSR_OFS_DMA_BUFFER) || dma_go);
  wire en_flip  = wr_cfg && (DATA_IN[`PCSR_CFG_IRQ_EN] != cfg[`PCSR_CFG_IRQ_EN]);
  wire ctx_clr  = eos_wr || en_flip;

  // ****************************************
  // request sources
  // ****************************************
  // the threshold inputs feed the DMA request only
  wire err_irq  = cfg[`PCSR_CFG_ERR_EN] && PIPE_DATA_ERROR;
  wire pipe_irq = cfg[`PCSR_CFG_IRQ_EN] && (PIPE_SERVICE_NEED || err_irq);
  wire port_irq = |(causes & irq_en);
  wire [2:0] src_now = src_code(flags[`PCSR_FLAG_PORT], flags[`PCSR_FLAG_PIPE]);

  assign ev.negotiation_change = NEG_STATE != neg_prev;
  assign ev.signal_change      = MANUAL_MODE && SIGNAL_STATE != sig_prev;
  assign ev.epp_addr_write_irq = EPP_ADDR_STROBE;
  assign ev.direction_change   = ECP_MODE && ECP_REVERSE != rev_prev;
  assign ev.id_request_irq     = ID_REQUEST;
  assign ev.init_pulse_irq     = COMPAT_MODE && INIT_PULSE;

  // a new cause wins over a clear in the same cycle
  assign next_causes = (causes & ~(wr_stat ? DATA_IN[5:0] : 6'h00)) | ev;

  assign base_flags = ctx_clr ? 3'h0 : wr_flags ? (flags & DATA_IN[7:5]) : flags;
  assign next_flags[`PCSR_FLAG_PIPE] = base_flags[`PCSR_FLAG_PIPE] || pipe_irq;
  assign next_flags[`PCSR_FLAG_PORT] = base_flags[`PCSR_FLAG_PORT] || port_irq;
  assign next_flags[`PCSR_FLAG_SUMMARY] = base_flags[`PCSR_FLAG_SUMMARY] ||
    next_flags[`PCSR_FLAG_PIPE] || next_flags[`PCSR_FLAG_PORT];

  // ****************************************
  // register read selection
  // ****************************************
  always_comb begin
    rd_val = `PCSR_RST8;
    unique case (ADDR)
      `PCSR_OFS_CHANNEL_SELECT: rd_val = chan_sel;
      `PCSR_OFS_PIPE_CONFIG:    rd_val = cfg;
      `PCSR_OFS_PIPE_STATUS:    rd_val = {7'h00, PIPE_DATA_ERROR};
      `PCSR_OFS_DATA_ERR_CAUSE: rd_val = DATA_ERROR_CAUSE;
      `PCSR_OFS_CHAN_IRQ_EN:    rd_val = {2'h0, irq_en};
      `PCSR_OFS_CHAN_IRQ_STAT:  rd_val = {2'h0, causes};
      `PCSR_OFS_NEG_STATUS:     rd_val = NEG_STATE;
      `PCSR_OFS_SIGNAL_STATUS:  rd_val = SIGNAL_STATE;
      `PCSR_OFS_EPP_ADDRESS:    rd_val = epp_addr;
      `PCSR_OFS_LOCAL_VECTOR:   rd_val = chan0 ?
        {vec_id, in_service ? src_now : `PCSR_SRC_NONE} : `PCSR_RST8;
      `PCSR_OFS_REQ_FLAGS:      rd_val = {flags, 5'h00};
      `PCSR_OFS_SUMMARY_SVC:    rd_val = {!DMA_REQUEST_OUT_N, 3'h0,
                                          flags[`PCSR_FLAG_SUMMARY], 3'h0};
      `PCSR_OFS_PRESENTED_VEC:  rd_val = pres_vec;
      default:                  rd_val = `PCSR_RST8;
    endcase
  end

  wire rd_buf = ADDR == `PCSR_OFS_DMA_BUFFER;
  wire [15:0] next_dout = ack_go ? {8'h00, vec_id, src_now} :
    ((dma_go || rd_buf) && dma_dir) ? DMA_TX_WORD : {8'h00, rd_val};
  wire drive = ack_go || (dma_go && dma_dir) || (go && kind.rd);

  // ****************************************
  // flip-flops
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ce         <= 1'b0;
      cfg        <= `PCSR_RST8;
      chan_sel   <= `PCSR_RST8;
      irq_en     <= 6'h00;
      causes     <= '0;
      flags      <= 3'h0;
      in_service <= 1'b0;
      vec_id     <= 5'h00;
      pres_vec   <= `PCSR_RST8;
      epp_addr   <= `PCSR_RST8;
      neg_prev   <= `PCSR_RST8;
      sig_prev   <= `PCSR_RST8;
      rev_prev   <= 1'b0;
    end else begin
      ce       <= !ce;
      neg_prev <= NEG_STATE;
      sig_prev <= SIGNAL_STATE;
      rev_prev <= ECP_REVERSE;
      causes   <= next_causes;
      flags    <= next_flags;
      if (EPP_ADDR_STROBE) epp_addr <= EPP_ADDR;
      if (wr_sel) chan_sel <= DATA_IN[7:0];
      if (wr_cfg) cfg <= DATA_IN[7:0];
      if (wr_ien) irq_en <= DATA_IN[5:0];
      if (wr_vec) vec_id <= DATA_IN[7:3];
      // low vector bits are stored only in pres_vec at acknowledge; the local vector follows the live source
      if (ack_go) begin
        in_service <= 1'b1;
        pres_vec   <= {vec_id, src_now};
      end else if (ctx_clr) begin
        in_service <= 1'b0;
        pres_vec   <= `PCSR_RST8;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      SVC_REQUEST_OUT_N <= 1'b1;
      DMA_REQUEST_OUT_N <= 1'b1;
      CHAIN_PASS_OUT_N  <= 1'b1;
      DATA_OUT          <= `PCSR_RST16;
      DATA_OE           <= 1'b0;
      DMA_TX_WORD       <= `PCSR_RST16;
      DMA_TX_LOAD       <= 1'b0;
    end else begin
      SVC_REQUEST_OUT_N <= !pending || ack_go;
      // request holds until near limit; dropping the enable removes it
      DMA_REQUEST_OUT_N <= !(cfg[`PCSR_CFG_DMA_EN] && (!DMA_REQUEST_OUT_N ?
                             !FIFO_NEAR_LIMIT : FIFO_THRESHOLD_HIT));
      // our own acknowledge on the bus must not hand the grant downstream
      CHAIN_PASS_OUT_N  <= !(!CHAIN_GRANT_IN_N && !pending && !DATA_OE);
      DMA_TX_LOAD       <= wr_buf;
      if (drive) DATA_OUT <= next_dout;
      if (drive) DATA_OE <= 1'b1;
      else if (DS_N && DMA_ACK_IN_N) DATA_OE <= 1'b0;
      if (wr_buf) DMA_TX_WORD <= DATA_IN;
      else if (dma_dir && PIPE_WORD_VALID) DMA_TX_WORD <= PIPE_WORD;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_svc_after_ack: assert property (
    ack_go |=> SVC_REQUEST_OUT_N [*2])
    else $error("service request not dropped by acknowledge");
  a_svc_raised: assert property (
    (pending && !ack_go) |=> !SVC_REQUEST_OUT_N)
    else $error("pending request not raised");
  a_svc_quiet: assert property (
    !flags[`PCSR_FLAG_SUMMARY] |=> SVC_REQUEST_OUT_N)
    else $error("service request without a source");
  a_pipe_flag: assert property (
    pipe_irq |=> flags[`PCSR_FLAG_PIPE] && flags[`PCSR_FLAG_SUMMARY])
    else $error("pipeline request not flagged");
  a_port_flag: assert property (
    (ev.id_request_irq && irq_en[4]) |=> ##1 flags[`PCSR_FLAG_PORT])
    else $error("port request not flagged");
  a_error_irq: assert property (
    (PIPE_DATA_ERROR && cfg[`PCSR_CFG_ERR_EN] && cfg[`PCSR_CFG_IRQ_EN]) |=>
    flags[`PCSR_FLAG_PIPE])
    else $error("data error interrupt missing");
  a_dma_disable: assert property (
    !cfg[`PCSR_CFG_DMA_EN] |=> DMA_REQUEST_OUT_N)
    else $error("dma request without enable");
  a_dma_hold: assert property (
    (!DMA_REQUEST_OUT_N && cfg[`PCSR_CFG_DMA_EN] && !FIFO_NEAR_LIMIT) |=>
    !DMA_REQUEST_OUT_N)
    else $error("dma request dropped early");
  a_chain_pass: assert property (
    (!CHAIN_GRANT_IN_N && !pending && !DATA_OE) |=> !CHAIN_PASS_OUT_N)
    else $error("grant not passed on");
  a_chain_own: assert property (
    (!CHAIN_GRANT_IN_N && DATA_OE) |=> CHAIN_PASS_OUT_N)
    else $error("grant passed during own acknowledge");
  a_chain_hold: assert property (
    (!CHAIN_GRANT_IN_N && pending) |=> CHAIN_PASS_OUT_N)
    else $error("grant passed while pending");
  a_vector_out: assert property (
    ack_go |=> DATA_OE && DATA_OUT[7:0] == {vec_id, $past(src_now)})
    else $error("wrong vector driven");
  a_eos_clear: assert property (
    (eos_wr && !ack_go) |=> !in_service && pres_vec == `PCSR_RST8)
    else $error("end of service did not clear context");

  c_ack_taken: cover property (ack_go ##[1:40] eos_wr);
  c_dma_burst: cover property (!DMA_REQUEST_OUT_N [*4]);
  c_pass_on:   cover property (!CHAIN_PASS_OUT_N);
endmodule // pcsr_top
